// file: design/scs_clk_ctrl.sv
module scs_clk_ctrl
    import scs_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire scs_tick_s ticks,
    input wire scs_wake_s wake,
    output logic int_osc_run,
    output logic sys_clk_tick,
    output logic core_clk_en,
    output logic resume_pulse
);

    // ==========================================================
    // Declarations
    // ==========================================================
    scs_src_e clk_src_reg;
    scs_src_e act_src_reg;
    logic [2:0] int_div_reg;
    logic [2:0] act_div_reg;
    logic [1:0] osc_en_reg;
    logic susp_reg;
    logic [6:0] div_cnt_reg;
    logic [3:0] settle_cnt_reg;
    logic ready_reg;
    logic sys_tick_reg;
    logic resume_reg;
    logic [31:0] prdata_reg;
    logic slverr_reg;
    logic setup;
    logic access;
    logic hit_src;
    logic hit_osc;
    logic wr_src;
    logic wr_osc;
    logic wake_evt;
    logic div_pulse;
    logic src_pulse;
    logic src_alive;
    logic switch_ok;
    logic [31:0] rd_next;

    // ==========================================================
    // APB decode
    // ==========================================================
    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign hit_src = (paddr == ADDR_CLK_SRC);
    assign hit_osc = (paddr == ADDR_OSC_CTL);
    assign wr_src = access & pwrite & hit_src;
    assign wr_osc = access & pwrite & hit_osc;
    assign pready = 1'b1;
    assign prdata = prdata_reg;
    assign pslverr = slverr_reg;

    // Read word assembled for the setup phase
    always_comb begin
        rd_next = RD_ZERO;
        if (hit_src) begin
            rd_next[SRC_HI:0] = clk_src_reg;
        end else if (hit_osc) begin
            rd_next[OSC_EN_HI:OSC_EN_LO] = osc_en_reg;
            rd_next[OSC_SUSP_BIT] = susp_reg;
            rd_next[OSC_RDY_BIT] = ready_reg;
            rd_next[OSC_RSV_BIT] = 1'b0;
            rd_next[DIV_HI:0] = int_div_reg;
        end
    end

    // Read data and error captured in setup, stable through access
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prdata_reg <= RD_ZERO;
            slverr_reg <= 1'b0;
        end else if (setup) begin
            prdata_reg <= pwrite ? RD_ZERO : rd_next;
            slverr_reg <= ~(hit_src | hit_osc);
        end
    end

    // ==========================================================
    // Software registers
    // ==========================================================
    // Reserved code 11 is dropped so the mux never sees it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            clk_src_reg <= SRC_INT;
        end else if (wr_src && pwdata[SRC_HI:0] != SRC_RSV) begin
            clk_src_reg <= scs_src_e'(pwdata[SRC_HI:0]);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            osc_en_reg <= OSC_EN_RST;
            int_div_reg <= DIV_RST;
        end else if (wr_osc) begin
            osc_en_reg <= pwdata[OSC_EN_HI:OSC_EN_LO];
            int_div_reg <= pwdata[DIV_HI:0];
        end
    end

    // ==========================================================
    // Suspend and wake
    // ==========================================================
    assign wake_evt = (|wake.port_match) | (wake.cmp0_enabled & ~wake.cmp0_out);

    // Wake beats a suspend write in the same cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            susp_reg <= 1'b0;
        end else if (wake_evt) begin
            susp_reg <= 1'b0;
        end else if (wr_osc && pwdata[OSC_SUSP_BIT]) begin
            susp_reg <= 1'b1;
        end
    end

    // One pulse to let the core step past the suspending write
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            resume_reg <= 1'b0;
        end else begin
            resume_reg <= susp_reg & wake_evt;
        end
    end

    assign resume_pulse = resume_reg;
    assign int_osc_run = (osc_en_reg == OSC_EN_ON) & ~susp_reg;
    assign core_clk_en = ~(susp_reg & (act_src_reg == SRC_INT));

    // ==========================================================
    // Frequency ready flag
    // ==========================================================
    always_ff @(posedge clk) begin
        if (!rst_n || !int_osc_run) begin
            settle_cnt_reg <= 4'h0;
            ready_reg <= 1'b0;
        end else if (ticks.int_osc && settle_cnt_reg != SETTLE_TICKS) begin
            settle_cnt_reg <= settle_cnt_reg + 4'h1;
        end else if (settle_cnt_reg == SETTLE_TICKS) begin
            ready_reg <= 1'b1;
        end
    end

    // ==========================================================
    // Divider and source mux
    // ==========================================================
    assign div_pulse = ticks.int_osc & int_osc_run
        & (div_cnt_reg == div_limit(act_div_reg));

    always_comb begin
        unique case (act_src_reg)
            SRC_INT: src_pulse = div_pulse;
            SRC_EXT: src_pulse = ticks.ext_osc;
            SRC_MUL: src_pulse = ticks.clk_mul;
            default: src_pulse = 1'b0;
        endcase
    end

    // A stopped internal source may be left at once; others only at a cycle end
    assign src_alive = (act_src_reg != SRC_INT) | int_osc_run;
    assign switch_ok = src_pulse | ~src_alive;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            act_src_reg <= SRC_INT;
            act_div_reg <= DIV_RST;
        end else if (switch_ok) begin
            act_src_reg <= clk_src_reg;
            act_div_reg <= int_div_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div_cnt_reg <= 7'h00;
        end else if (switch_ok && act_div_reg != int_div_reg) begin
            div_cnt_reg <= 7'h00;
        end else if (div_pulse) begin
            div_cnt_reg <= 7'h00;
        end else if (ticks.int_osc && int_osc_run) begin
            div_cnt_reg <= div_cnt_reg + 7'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sys_tick_reg <= 1'b0;
        end else begin
            sys_tick_reg <= src_pulse & core_clk_en;
        end
    end

    assign sys_clk_tick = sys_tick_reg;

    // ==========================================================
    // Checks
    // ==========================================================
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    property p_int_src;
        (act_src_reg == SRC_INT && div_pulse && !susp_reg) |=> sys_clk_tick;
    endproperty
    a_int_src: assert property (p_int_src) else $error("internal tick lost");

    property p_ext_src;
        (act_src_reg == SRC_EXT && ticks.ext_osc) |=> sys_clk_tick;
    endproperty
    a_ext_src: assert property (p_ext_src) else $error("external tick lost");

    property p_mul_src;
        (act_src_reg == SRC_MUL) |-> (src_pulse == ticks.clk_mul) && clk_src_reg != SRC_RSV;
    endproperty
    a_mul_src: assert property (p_mul_src) else $error("multiplier path wrong");

    property p_src_upper;
        (setup && hit_src && !pwrite) |=> prdata[31:2] == 30'h0;
    endproperty
    a_src_upper: assert property (p_src_upper) else $error("select upper bits set");

    property p_reset;
        disable iff (1'b0)
        !rst_n |=> clk_src_reg == SRC_INT && act_src_reg == SRC_INT
            && int_div_reg == DIV_RST && osc_en_reg == OSC_EN_ON;
    endproperty
    a_reset: assert property (p_reset) else $error("bad reset state");

    property p_div_by_one;
        (act_div_reg == DIV_BY_ONE && ticks.int_osc && int_osc_run) |-> div_pulse;
    endproperty
    a_div_by_one: assert property (p_div_by_one) else $error("divide by one miss");

    property p_div_reset;
        disable iff (1'b0)
        !rst_n |=> div_limit(act_div_reg) == 7'h7F;
    endproperty
    a_div_reset: assert property (p_div_reset) else $error("divider not 128");

    property p_suspend;
        (wr_osc && pwdata[OSC_SUSP_BIT] && !wake_evt) |=> susp_reg && !int_osc_run;
    endproperty
    a_suspend: assert property (p_suspend) else $error("suspend ignored");

    property p_gate;
        (susp_reg && act_src_reg == SRC_INT) |=> !sys_clk_tick;
    endproperty
    a_gate: assert property (p_gate) else $error("clock not gated");

    property p_wake;
        (susp_reg && wake_evt) |=> !susp_reg && core_clk_en ##0 resume_pulse;
    endproperty
    a_wake: assert property (p_wake) else $error("wake not taken");

    property p_resume;
        $fell(susp_reg) && $past(rst_n) |-> resume_pulse ##1 !resume_pulse;
    endproperty
    a_resume: assert property (p_resume) else $error("resume pulse wrong");

    property p_enable;
        (osc_en_reg != OSC_EN_ON) |-> !int_osc_run && !div_pulse;
    endproperty
    a_enable: assert property (p_enable) else $error("disabled osc runs");

    property p_ready;
        !int_osc_run |=> !ready_reg;
    endproperty
    a_ready: assert property (p_ready) else $error("ready while stopped");

    property p_rsv_bit;
        (setup && hit_osc && !pwrite) |=> !prdata[OSC_RSV_BIT];
    endproperty
    a_rsv_bit: assert property (p_rsv_bit) else $error("reserved bit set");

    property p_glitch;
        $changed(act_src_reg) && $past(rst_n) |-> $past(switch_ok);
    endproperty
    a_glitch: assert property (p_glitch) else $error("switch mid cycle");

    property p_src_keep;
        (wr_src && pwdata[SRC_HI:0] == SRC_RSV) |=> $stable(clk_src_reg);
    endproperty
    a_src_keep: assert property (p_src_keep) else $error("reserved select taken");

    property p_src_write;
        (wr_src && pwdata[SRC_HI:0] != SRC_RSV)
            |=> clk_src_reg == $past(pwdata[SRC_HI:0]);
    endproperty
    a_src_write: assert property (p_src_write) else $error("select write lost");

    property p_osc_write;
        wr_osc |=> osc_en_reg == $past(pwdata[OSC_EN_HI:OSC_EN_LO])
            && int_div_reg == $past(pwdata[DIV_HI:0]);
    endproperty
    a_osc_write: assert property (p_osc_write) else $error("control write lost");

    property p_ready_set;
        (int_osc_run && settle_cnt_reg == SETTLE_TICKS) |=> ready_reg;
    endproperty
    a_ready_set: assert property (p_ready_set) else $error("ready not raised");

    property p_div_restart;
        (switch_ok && act_div_reg != int_div_reg) |=> div_cnt_reg == 7'h00;
    endproperty
    a_div_restart: assert property (p_div_restart) else $error("divider not restarted");

    property p_susp_hold;
        (susp_reg && !wake_evt) |=> susp_reg;
    endproperty
    a_susp_hold: assert property (p_susp_hold) else $error("suspend left early");

    property p_no_resume;
        !(susp_reg && wake_evt) |=> !resume_pulse;
    endproperty
    a_no_resume: assert property (p_no_resume) else $error("stray resume pulse");

    property p_core_on;
        !susp_reg |-> core_clk_en;
    endproperty
    a_core_on: assert property (p_core_on) else $error("core gated while awake");

    property p_ext_idle;
        (act_src_reg == SRC_EXT && !ticks.ext_osc) |=> !sys_clk_tick;
    endproperty
    a_ext_idle: assert property (p_ext_idle) else $error("external extra tick");

endmodule

// file: design/scs_pkg.sv
package scs_pkg;

    // ==========================================================
    // Register map
    // ==========================================================
    localparam int APB_AW = 12;
    localparam logic [7:0] IDX_CLK_SRC = 8'h8F;
    localparam logic [7:0] IDX_OSC_CTL = 8'hA1;
    localparam logic [11:0] ADDR_CLK_SRC = {2'h0, IDX_CLK_SRC, 2'h0};
    localparam logic [11:0] ADDR_OSC_CTL = {2'h0, IDX_OSC_CTL, 2'h0};

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int SRC_HI = 1;
    localparam int OSC_EN_HI = 7;
    localparam int OSC_EN_LO = 6;
    localparam int OSC_SUSP_BIT = 5;
    localparam int OSC_RDY_BIT = 4;
    localparam int OSC_RSV_BIT = 3;
    localparam int DIV_HI = 2;

    // ==========================================================
    // Encodings and reset values
    // ==========================================================
    typedef enum logic [1:0] {
        SRC_INT = 2'b00,
        SRC_EXT = 2'b01,
        SRC_MUL = 2'b10,
        SRC_RSV = 2'b11
    } scs_src_e;

    localparam logic [1:0] OSC_EN_ON = 2'h3;
    localparam logic [1:0] OSC_EN_OFF = 2'h0;
    localparam logic [1:0] OSC_EN_RST = OSC_EN_ON;
    localparam logic [2:0] DIV_RST = 3'h0;
    localparam logic [2:0] DIV_BY_ONE = 3'h7;
    localparam logic [7:0] DIV_MAX = 8'h80;
    localparam logic [3:0] SETTLE_TICKS = 4'hF;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;

    // ==========================================================
    // Carriers
    // ==========================================================
    typedef struct packed {
        logic int_osc;
        logic ext_osc;
        logic clk_mul;
    } scs_tick_s;

    typedef struct packed {
        logic [3:0] port_match;
        logic cmp0_enabled;
        logic cmp0_out;
    } scs_wake_s;

    // Terminal count of the divider: code 0 gives 127 (divide by 128), code 7 gives 0 (divide by 1)
    function automatic logic [6:0] div_limit(input logic [2:0] code);
        logic [7:0] n;
        n = DIV_MAX >> code;
        return 7'(n - 8'h01);
    endfunction

endpackage

// file: bench/system_clock_signal_select_and_int_osc_ctrl_test.sv
module system_clock_signal_select_and_int_osc_ctrl_test
    import scs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    // ==========================================================
    // Signals and model state
    // ==========================================================
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [APB_AW-1:0] paddr = '0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    scs_tick_s ticks = '0;
    scs_wake_s wake = '0;
    logic int_osc_run;
    logic sys_clk_tick;
    logic core_clk_en;
    logic resume_pulse;
    int n_mismatch = 0;
    int checked = 0;
    int n_sys = 0;
    int n_res = 0;
    int m_src = 0;
    int m_div = 0;
    int m_en = 3;
    int m_susp = 0;
    int m_rdy = 0;
    logic [7:0] seed = 8'h36;
    logic [5:0] wake_tab [5] = '{6'h04, 6'h08, 6'h10, 6'h20, 6'h02};

    scs_clk_ctrl u_dut (
        .clk(clk),
        .rst_n(rst_n),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .ticks(ticks),
        .wake(wake),
        .int_osc_run(int_osc_run),
        .sys_clk_tick(sys_clk_tick),
        .core_clk_en(core_clk_en),
        .resume_pulse(resume_pulse)
    );

    always #25 clk = ~clk;

    always @(posedge clk) begin
        if (sys_clk_tick === 1'b1) n_sys++;
        if (resume_pulse === 1'b1) n_res++;
        if (rst_n === 1'b1) chk("tick outputs known", 32'h0, {31'h0, $isunknown({sys_clk_tick, resume_pulse})});
    end

    // ==========================================================
    // Helpers
    // ==========================================================
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    function automatic logic [31:0] osc_val();
        return 32'(m_en * 64 + m_susp * 32 + m_rdy * 16 + m_div);
    endfunction

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic chk_cnt(input string what, input int exp, input int got);
        checked++;
        if (got != exp) begin
            n_mismatch++;
            $display("unexpected %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic err;
        apb(1'b1, a, d, rd, err);
        if (a == ADDR_CLK_SRC && d[1:0] != 2'b11) m_src = int'(d[1:0]);
        if (a == ADDR_OSC_CTL) begin
            m_en = int'(d[7:6]);
            m_div = int'(d[2:0]);
            if (d[5]) m_susp = 1;
        end
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
        logic [31:0] rd;
        logic err;
        apb(1'b0, a, 32'h0, rd, err);
        chk("read data", exp, rd);
        chk("slave error", {31'h0, exp_err}, {31'h0, err});
    endtask

    // Pulses source ticks, returns system ticks seen
    task automatic pulse(input logic [2:0] m, input int n, output int cnt);
        int s;
        s = n_sys;
        repeat (n) begin
            @(posedge clk);
            ticks <= scs_tick_s'(m);
            @(posedge clk);
            ticks <= '0;
        end
        repeat (3) @(posedge clk);
        cnt = n_sys - s;
    endtask

    task automatic finish_test();
        $display("mismatches %0d comparisons %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge clk);
        n_mismatch++;
        finish_test();
    end

    // ==========================================================
    // Scenarios
    // ==========================================================
    initial begin
        int c;
        int cnt;
        int s;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        chk("run after reset", 32'h1, {31'h0, int_osc_run});
        rd_chk(ADDR_CLK_SRC, 32'h0, 1'b0);
        rd_chk(ADDR_OSC_CTL, osc_val(), 1'b0);
        rd_chk(12'h100, 32'h0, 1'b1);
        seed = lfsr(seed);
        wr(ADDR_CLK_SRC, {24'h0, seed | 8'h03});
        rd_chk(ADDR_CLK_SRC, 32'h0, 1'b0);
        for (c = 7; c >= 0; c--) begin
            seed = lfsr(seed);
            wr(ADDR_OSC_CTL, {seed, 16'h0, 8'hC0 | 8'(c)});
            pulse(3'h4, 256, cnt);
            pulse(3'h4, 128, cnt);
            chk_cnt("divided ticks", 1 << c, cnt);
        end
        m_rdy = 1;
        rd_chk(ADDR_OSC_CTL, osc_val(), 1'b0);
        seed = lfsr(seed);
        wr(ADDR_CLK_SRC, {24'h0, (seed & 8'hFC) | 8'h01});
        rd_chk(ADDR_CLK_SRC, 32'(m_src), 1'b0);
        pulse(3'h4, 256, cnt);
        pulse(3'h4, 64, cnt);
        chk_cnt("internal ticks while external", 0, cnt);
        pulse(3'h2, 10, cnt);
        chk_cnt("external ticks", 10, cnt);
        wr(ADDR_CLK_SRC, 32'h2);
        pulse(3'h2, 4, cnt);
        pulse(3'h1, 10, cnt);
        chk_cnt("multiplier ticks", 10, cnt);
        wr(ADDR_CLK_SRC, 32'h0);
        pulse(3'h1, 4, cnt);
        wr(ADDR_OSC_CTL, 32'hC7);
        pulse(3'h4, 256, cnt);
        for (c = 0; c < 5; c++) begin
            // Tempco enable lives outside this block, taken as set
            wr(ADDR_OSC_CTL, 32'hE7);
            @(posedge clk);
            chk("run in suspend", 32'h0, {31'h0, int_osc_run});
            chk("core enable in suspend", 32'h0, {31'h0, core_clk_en});
            pulse(3'h4, 8, cnt);
            chk_cnt("ticks in suspend", 0, cnt);
            m_rdy = 0;
            rd_chk(ADDR_OSC_CTL, osc_val(), 1'b0);
            wake <= scs_wake_s'(6'h03);
            repeat (4) @(posedge clk);
            chk("core enable without wake", 32'h0, {31'h0, core_clk_en});
            s = n_res;
            wake <= scs_wake_s'(wake_tab[c]);
            repeat (3) @(posedge clk);
            wake <= '0;
            repeat (2) @(posedge clk);
            m_susp = 0;
            chk_cnt("resume pulses", 1, n_res - s);
            chk("run after wake", 32'h1, {31'h0, int_osc_run});
            chk("core enable after wake", 32'h1, {31'h0, core_clk_en});
            pulse(3'h4, 8, cnt);
            chk_cnt("ticks after wake", 8, cnt);
        end
        wr(ADDR_OSC_CTL, 32'h07);
        @(posedge clk);
        chk("run when disabled", 32'h0, {31'h0, int_osc_run});
        wr(ADDR_OSC_CTL, 32'h47);
        @(posedge clk);
        chk("run with reserved enable", 32'h0, {31'h0, int_osc_run});
        rd_chk(ADDR_OSC_CTL, osc_val(), 1'b0);
        // Reset in mid run must restore select and divider
        wr(ADDR_CLK_SRC, 32'h2);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        m_src = 0;
        m_en = 3;
        m_div = 0;
        rd_chk(ADDR_CLK_SRC, 32'(m_src), 1'b0);
        rd_chk(ADDR_OSC_CTL, osc_val(), 1'b0);
        pulse(3'h4, 128, cnt);
        chk_cnt("ticks after reset", 1, cnt);
        finish_test();
    end
endmodule
